// >>> hw/phy_control_a_upper_bits.sv
`timescale 1ns/10ps
`default_nettype none
`include "phy_ctrl_a_defs.svh"

module phy_control_a_upper_bits
    import phy_ctrl_a_pkg::*;
#(
    parameter int NOISE_WIDTH = 16,
    parameter int CONN_WIDTH  = 16
)
(
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   reset_i,
    // Register port, synchronous to sys_clk
    input  wire np_req_type             np_req_i,
    output logic      [15:0]            np_data_o,
    output logic                        np_data_oe_o,
    // Connection manager and line state
    input  wire pcm_state_type          pcm_state_i,
    input  wire line_state_type         line_state_i,
    input  wire logic                   config_override_i,
    // Timers
    input  wire logic [NOISE_WIDTH-1:0] noise_limit_value_i,
    input  wire logic                   conn_load_i,
    input  wire logic [CONN_WIDTH-1:0]  conn_load_value_i,
    output logic      [NOISE_WIDTH-1:0] noise_event_timer_o,
    output logic      [CONN_WIDTH-1:0]  connection_timer_o,
    // Receive byte path and scrub
    input  wire logic [9:0]             rx_byte_i,
    output logic      [9:0]             rx_byte_o,
    // Transmit symbol path
    input  wire logic [4:0]             tx_symbol_i,
    input  wire logic [4:0]             maintenance_line_state_i,
    output logic      [4:0]             transmit_symbol_port_o,
    // Transmit byte input with parity
    input  wire logic [9:0]             tx_byte_i,
    input  wire logic                   tx_parity_i,
    input  wire logic                   tx_byte_valid_i,
    // Counter inputs and outputs, and the idle minimum detect input
    input  wire logic                   violation_symbol_i,
    input  wire logic                   violation_clear_i,
    input  wire logic                   idle_gap_detect_i,
    input  wire logic                   idle_min_detect_i,
    input  wire logic                   idle_gap_clear_i,
    output logic [`VIOL_CNT_BITS-1:0]   violation_symbol_counter_o,
    output logic [`IDLE_GAP_CNT_BITS-1:0] min_idle_gap_counter_o,
    // Event pulses
    output event_pulse_type             events_o,
    // External loopback pin, active low
    output logic                        external_loop_pin_n_o
);

    // Decodes a line state that counts as leaving idle
    function automatic logic is_non_idle(input line_state_type ls);
        is_non_idle = (ls == LS_NOISE) || (ls == LS_ACTIVE) || (ls == LS_UNKNOWN);
    endfunction

    // Control register and bus state
    logic [15:0]    ctrl_a_r;
    logic [15:0]    ctrl_a_nxt;
    bus_state_type  bus_r;
    bus_state_type  bus_nxt;
    logic           read_r;
    logic [4:0]     addr_r;

    // Tick divider for the 80 ns timer base
    localparam int TICK_CYC = (`TIMER_TICK_CYCLES < 1) ? 1 : `TIMER_TICK_CYCLES;
    logic [7:0]     tick_cnt_r;
    wire            tick;

    // Other state
    line_state_type ls_prev_r;
    wire            in_maintenance_state;
    wire            restr_ok;
    wire            scrub_ctl;
    wire            noise_active;
    wire            leave_idle;
    wire            addr_hit;
    wire            wr_strobe;
    wire            rd_drive;
    wire [15:0]     wr_masked;
    wire            noise_expired;
    wire            conn_expired;
    wire            viol_event;
    wire            gap_event;

    // Connection manager state decodes
    assign in_maintenance_state = (pcm_state_i == PCM_MAINTENANCE_STATE);
    assign restr_ok = (pcm_state_i == PCM_OFF) || in_maintenance_state;

    assign scrub_ctl = (in_maintenance_state || config_override_i) && ctrl_a_r[`BIT_SCRUB_REQ];

    // maintenance needs bit 14
    // Outside maintenance the connection manager uses noise timing unless off
    assign noise_active = in_maintenance_state ? ctrl_a_r[`BIT_NOISE_TIMING] : (pcm_state_i != PCM_OFF);

    assign leave_idle = noise_active && (ls_prev_r == LS_IDLE) && is_non_idle(line_state_i);

    // Register port decode; only address 00 belongs to this block
    assign addr_hit  = (addr_r == `CTRL_A_ADDR);
    assign wr_strobe = (bus_r == BUS_ACCESS) && !read_r && addr_hit;
    assign rd_drive  = read_r && addr_hit && (bus_r != BUS_IDLE);

    assign wr_masked = np_req_i.wdata & `CTRL_A_IMPL_MASK;

    // Next register value on a write
    always_comb
    begin
        ctrl_a_nxt = ctrl_a_r;
        if (wr_strobe)
        begin
            if (restr_ok)
                ctrl_a_nxt = wr_masked;
            else
                ctrl_a_nxt = (wr_masked & ~`CTRL_A_RESTR_MASK)
                           | (ctrl_a_r & `CTRL_A_RESTR_MASK);
        end
    end

    // Bus sequencing: chip select sampled, data taken one edge later,
    // one access per chip select, drive released two edges after release
    always_comb
    begin
        bus_nxt = bus_r;
        case (bus_r)
            BUS_IDLE:
                if (!np_req_i.cs_n)
                    bus_nxt = BUS_ACCESS;
            BUS_ACCESS:
                bus_nxt = BUS_HOLD;
            BUS_HOLD:
                if (np_req_i.cs_n)
                    bus_nxt = BUS_TAIL;
            BUS_TAIL:
                bus_nxt = BUS_IDLE;
            default:
                bus_nxt = BUS_IDLE;
        endcase
    end

    // Bus state and captured address
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            bus_r  <= BUS_IDLE;
            read_r <= 1'b0;
            addr_r <= 5'h00;
        end
        else
        begin
            bus_r <= bus_nxt;
            if (bus_r == BUS_IDLE && !np_req_i.cs_n)
            begin
                read_r <= np_req_i.read;
                addr_r <= np_req_i.addr;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            ctrl_a_r <= `CTRL_A_RESET;
        else
            ctrl_a_r <= ctrl_a_nxt;
    end

    // Read data from flops; the register is held stable across the access
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            np_data_o    <= 16'h0000;
            np_data_oe_o <= 1'b0;
        end
        else
        begin
            np_data_o    <= ctrl_a_r & `CTRL_A_IMPL_MASK;
            np_data_oe_o <= rd_drive && (bus_nxt != BUS_IDLE);
        end
    end

    // Timer base: one enable pulse every 80 ns
    assign tick = (tick_cnt_r == 8'(TICK_CYC - 1));

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            tick_cnt_r <= 8'h00;
        else if (tick)
            tick_cnt_r <= 8'h00;
        else
            tick_cnt_r <= tick_cnt_r + 8'h01;
    end

    // Previous line state for transition detection
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            ls_prev_r <= LS_QUIET;
        else
            ls_prev_r <= line_state_i;
    end

    // expiry before idle
    // Return to idle, or noise timing switched off, stops the timer
    prescaled_timer #(
        .WIDTH    (NOISE_WIDTH),
        .PRE_BITS (`NOISE_PRE_BITS)
    ) noise_timer (
        .sys_clk_i    (sys_clk_i),
        .reset_i      (reset_i),
        .tick_i       (tick),
        .wide_i       (ctrl_a_r[`BIT_NOISE_WIDE]),
        .load_i       (leave_idle),
        .load_value_i (noise_limit_value_i),
        .run_i        (noise_active && (line_state_i != LS_IDLE)),
        .count_o      (noise_event_timer_o),
        .expired_o    (noise_expired)
    );

    prescaled_timer #(
        .WIDTH    (CONN_WIDTH),
        .PRE_BITS (`CONN_PRE_BITS)
    ) conn_timer (
        .sys_clk_i    (sys_clk_i),
        .reset_i      (reset_i),
        .tick_i       (tick),
        .wide_i       (ctrl_a_r[`BIT_CONN_WIDE]),
        .load_i       (conn_load_i),
        .load_value_i (conn_load_value_i),
        .run_i        (1'b1),
        .count_o      (connection_timer_o),
        .expired_o    (conn_expired)
    );

    event_counter #(
        .WIDTH (`VIOL_CNT_BITS)
    ) viol_counter (
        .sys_clk_i       (sys_clk_i),
        .reset_i         (reset_i),
        .inc_i           (violation_symbol_i),
        .clear_i         (violation_clear_i),
        .overflow_only_i (ctrl_a_r[`BIT_VIOL_OVF_ONLY]),
        .count_o         (violation_symbol_counter_o),
        .event_o         (viol_event)
    );

    event_counter #(
        .WIDTH (`IDLE_GAP_CNT_BITS)
    ) gap_counter (
        .sys_clk_i       (sys_clk_i),
        .reset_i         (reset_i),
        .inc_i           (idle_gap_detect_i),
        .clear_i         (idle_gap_clear_i),
        .overflow_only_i (ctrl_a_r[`BIT_IDLE_OVF_ONLY]),
        .count_o         (min_idle_gap_counter_o),
        .event_o         (gap_event)
    );

    // Data paths and event outputs, all registered
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rx_byte_o              <= 10'h000;
            transmit_symbol_port_o <= 5'h00;
            events_o               <= '0;
            external_loop_pin_n_o  <= 1'b1;
        end
        else
        begin
            rx_byte_o <= scrub_ctl ? `IDLE_BYTE : rx_byte_i;
            transmit_symbol_port_o <= in_maintenance_state ? maintenance_line_state_i : tx_symbol_i;
            events_o.noise_timer_expired_flag <= noise_expired;
            events_o.conn_timer_expired       <= conn_expired;
            events_o.violation_count_event    <= viol_event;
            events_o.idle_gap_count_event     <= gap_event;
            events_o.idle_min_event <= idle_min_detect_i;
            events_o.tx_parity_error <= ctrl_a_r[`BIT_TX_PARITY_EN] && tx_byte_valid_i
                                        && (^{tx_byte_i, tx_parity_i});
            external_loop_pin_n_o <= ~ctrl_a_r[`BIT_EXT_LOOP];
        end
    end

endmodule

`default_nettype wire

// >>> common/phy_ctrl_a_defs.svh
`ifndef PHY_CTRL_A_DEFS_SVH
`define PHY_CTRL_A_DEFS_SVH

// Register address of control_register_a on the register port
`define CTRL_A_ADDR         5'h00
`define CTRL_A_RESET        16'h0000
// Bits implemented in this block; all others read as zero
`define CTRL_A_IMPL_MASK    16'h7F80
// Bits writable only in the off or maintenance state
`define CTRL_A_RESTR_MASK   16'h3000

// Field positions
`define BIT_RESERVED        15
`define BIT_NOISE_TIMING    14
`define BIT_NOISE_WIDE      13
`define BIT_CONN_WIDE       12
`define BIT_SCRUB_REQ       11
`define BIT_TX_PARITY_EN    10
`define BIT_VIOL_OVF_ONLY   9
`define BIT_IDLE_OVF_ONLY   8
`define BIT_EXT_LOOP        7

// Timer base rate
`define CLK_PERIOD_NS       40
`define TIMER_TICK_NS       80
`define TIMER_TICK_CYCLES   (`TIMER_TICK_NS / `CLK_PERIOD_NS)

// Prescaler widths of the narrow timer modes
`define NOISE_PRE_BITS      2
`define CONN_PRE_BITS       8

// Counter widths: overflow at 256 and at 16
`define VIOL_CNT_BITS       8
`define IDLE_GAP_CNT_BITS   4

// Idle symbol pair on the receive byte port
`define IDLE_BYTE           10'h3FF

`endif

// >>> common/phy_ctrl_a_pkg.sv
package phy_ctrl_a_pkg;

    // Connection manager state, driven by the connection manager
    typedef enum logic [3:0] {
        PCM_OFF     = 4'h0,
        PCM_BREAK   = 4'h1,
        PCM_TRACE   = 4'h2,
        PCM_CONNECT = 4'h3,
        PCM_NEXT    = 4'h4,
        PCM_SIGNAL  = 4'h5,
        PCM_JOIN    = 4'h6,
        PCM_VERIFY  = 4'h7,
        PCM_ACTIVE  = 4'h8,
        PCM_MAINTENANCE_STATE   = 4'h9
    } pcm_state_type;

    // Line state from the line state machine
    typedef enum logic [2:0] {
        LS_QUIET   = 3'h0,
        LS_IDLE    = 3'h1,
        LS_NOISE   = 3'h2,
        LS_ACTIVE  = 3'h3,
        LS_UNKNOWN = 3'h4,
        LS_HALT    = 3'h5,
        LS_MASTER  = 3'h6
    } line_state_type;

    // Register port access states
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_ACCESS = 2'b01,
        BUS_HOLD   = 2'b10,
        BUS_TAIL   = 2'b11
    } bus_state_type;

    // Register port request, sampled on sys_clk
    typedef struct packed {
        logic        cs_n;
        logic        read;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } np_req_type;

    // One-cycle event pulses toward the event flag register
    typedef struct packed {
        logic noise_timer_expired_flag;
        logic conn_timer_expired;
        logic violation_count_event;
        logic idle_gap_count_event;
        logic idle_min_event;
        logic tx_parity_error;
    } event_pulse_type;

endpackage

// >>> hw/prescaled_timer.sv
`timescale 1ns/10ps
`default_nettype none

module prescaled_timer
    import phy_ctrl_a_pkg::*;
#(
    parameter int WIDTH    = 16,
    parameter int PRE_BITS = 2
)
(
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    // Control
    input  wire logic             tick_i,
    input  wire logic             wide_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] load_value_i,
    input  wire logic             run_i,
    // Status
    output logic      [WIDTH-1:0] count_o,
    output logic                  expired_o
);

    logic [PRE_BITS-1:0] pre_r;
    logic                running_r;
    wire                 advance;
    wire                 at_zero;

    // Wide mode bypasses the prescaler, so the timer moves on every tick
    assign advance = tick_i && running_r && (wide_i || (&pre_r));
    assign at_zero = (count_o == '0);

    // Prescaler, reset on each load so the first period is whole
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            pre_r <= '0;
        else if (load_i)
            pre_r <= '0;
        else if (tick_i && running_r)
            pre_r <= pre_r + 1'b1;
    end

    // Down counter; expiry fires once, then the timer stops
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            count_o   <= '0;
            running_r <= 1'b0;
            expired_o <= 1'b0;
        end
        else
        begin
            expired_o <= 1'b0;
            if (load_i)
            begin
                count_o   <= load_value_i;
                running_r <= 1'b1;
            end
            else if (!run_i)
                running_r <= 1'b0;
            else if (advance && at_zero)
            begin
                running_r <= 1'b0;
                expired_o <= 1'b1;
            end
            else if (advance)
                count_o <= count_o - 1'b1;
        end
    end

endmodule

`default_nettype wire

// >>> hw/event_counter.sv
`timescale 1ns/10ps
`default_nettype none

module event_counter
    import phy_ctrl_a_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    // Control
    input  wire logic             inc_i,
    input  wire logic             clear_i,
    input  wire logic             overflow_only_i,
    // Status
    output logic      [WIDTH-1:0] count_o,
    output logic                  event_o
);

    wire overflow;

    // Wrap from all ones back to zero is the overflow
    assign overflow = inc_i && (&count_o);

    // An increment in the clearing cycle still counts, so none is lost
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            count_o <= '0;
            event_o <= 1'b0;
        end
        else
        begin
            if (clear_i)
                count_o <= inc_i ? WIDTH'(1) : '0;
            else if (inc_i)
                count_o <= count_o + 1'b1;
            event_o <= overflow_only_i ? overflow : inc_i;
        end
    end

endmodule

`default_nettype wire

// >>> sim/phy_ctrl_a_checker.sv
`timescale 1ns/10ps
`default_nettype none

module phy_ctrl_a_checker
    import phy_ctrl_a_pkg::*;
#(
    parameter int NOISE_WIDTH = 16
)
(
    // Clock and reset
    input wire logic                   sys_clk_i,
    input wire logic                   reset_i,
    // Register port
    input wire np_req_type             np_req_i,
    input wire logic [15:0]            np_data_o,
    input wire logic                   np_data_oe_o,
    // Modes and data paths
    input wire pcm_state_type          pcm_state_i,
    input wire logic                   config_override_i,
    input wire logic [9:0]             rx_byte_i,
    input wire logic [9:0]             rx_byte_o,
    input wire logic [4:0]             maintenance_line_state_i,
    input wire logic [4:0]             transmit_symbol_port_o,
    // Counters, timer and events
    input wire logic                   violation_symbol_i,
    input wire logic                   violation_clear_i,
    input wire logic                   idle_gap_detect_i,
    input wire logic                   idle_min_detect_i,
    input wire logic [7:0]             violation_symbol_counter_o,
    input wire logic [NOISE_WIDTH-1:0] noise_event_timer_o,
    input wire event_pulse_type        events_o,
    input wire logic                   external_loop_pin_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // Access steps: select taken, then the data bus held two edges
    sequence s_rd_take;
        $fell(np_req_i.cs_n) && np_req_i.read && np_req_i.addr == 5'h00;
    endsequence
    sequence s_other_take;
        $fell(np_req_i.cs_n) && np_req_i.addr != 5'h00;
    endsequence
    sequence s_drive2;
        np_data_oe_o ##1 np_data_oe_o;
    endsequence

    property p_rd_drive;
        s_rd_take |=> ##1 s_drive2;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("read not driven");
    property p_unmapped;
        s_other_take |=> !np_data_oe_o [*2];
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped drive");
    property p_reset;
        $fell(reset_i) |-> external_loop_pin_n_o && !np_data_oe_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset values wrong");
    property p_reserved;
        np_data_oe_o && $past(np_data_oe_o) |-> !np_data_o[15] && np_data_o[6:0] == 7'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits set");
    property p_loop;
        np_data_oe_o && $past(np_data_oe_o) |-> np_data_o[7] == !external_loop_pin_n_o;
    endproperty
    a_loop: assert property (p_loop)
        else $error("loop pin disagrees with register");
    property p_tx_sym;
        pcm_state_i == PCM_MAINTENANCE_STATE |=> transmit_symbol_port_o == $past(maintenance_line_state_i);
    endproperty
    a_tx_sym: assert property (p_tx_sym)
        else $error("tx symbol wrong");
    property p_no_scrub;
        pcm_state_i != PCM_MAINTENANCE_STATE && !config_override_i |=> rx_byte_o == $past(rx_byte_i);
    endproperty
    a_no_scrub: assert property (p_no_scrub)
        else $error("scrub misapplied");
    property p_viol_inc;
        violation_symbol_i && !violation_clear_i |=>
            violation_symbol_counter_o == $past(violation_symbol_counter_o) + 8'h01;
    endproperty
    a_viol_inc: assert property (p_viol_inc)
        else $error("violation count missed");
    property p_viol_src;
        events_o.violation_count_event |-> $past(violation_symbol_i) || $past(violation_symbol_i, 2);
    endproperty
    a_viol_src: assert property (p_viol_src)
        else $error("violation event without a symbol");
    property p_gap_src;
        events_o.idle_gap_count_event |-> $past(idle_gap_detect_i) || $past(idle_gap_detect_i, 2);
    endproperty
    a_gap_src: assert property (p_gap_src)
        else $error("idle gap event without a gap");
    property p_min_evt;
        idle_min_detect_i |-> ##[1:2] events_o.idle_min_event;
    endproperty
    a_min_evt: assert property (p_min_evt)
        else $error("idle minimum event lost");
    property p_noise_exp;
        events_o.noise_timer_expired_flag |-> $past(noise_event_timer_o) == '0;
    endproperty
    a_noise_exp: assert property (p_noise_exp)
        else $error("noise expiry before timer ran out");
endmodule

`default_nettype wire

// >>> sim/np_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module np_host_model
    import phy_ctrl_a_pkg::*;
(
    // Clock
    input  wire logic        sys_clk_i,
    // Register port
    output var  np_req_type  np_req_o,
    input  wire logic [15:0] np_data_i,
    input  wire logic        np_data_oe_i
);
    // Deselected bus; data lines carry a pattern, never a stale word
    initial np_req_o = '{cs_n: 1'b1, read: 1'b1, addr: 5'h1F, wdata: 16'hA5A5};

    // Write: select held over the edge that takes the data, then a tail
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        np_req_o <= '{cs_n: 1'b0, read: 1'b0, addr: a, wdata: d};
        repeat (2) @(posedge sys_clk_i);
        np_req_o <= '{cs_n: 1'b1, read: 1'b1, addr: ~a, wdata: ~d};
        repeat (3) @(posedge sys_clk_i);
    endtask

    // Read: data taken at the edge before release, so it is settled
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic oe);
        @(posedge sys_clk_i);
        np_req_o <= '{cs_n: 1'b0, read: 1'b1, addr: a, wdata: 16'h5A5A};
        repeat (3) @(posedge sys_clk_i);
        d = np_data_i;
        oe = np_data_oe_i;
        np_req_o <= '{cs_n: 1'b1, read: 1'b1, addr: ~a, wdata: 16'hA5A5};
        repeat (3) @(posedge sys_clk_i);
    endtask
endmodule

`default_nettype wire

// >>> sim/phy_control_a_upper_bits_tb.sv
`timescale 1ns/10ps
`default_nettype none

module phy_control_a_upper_bits_tb
    import phy_ctrl_a_pkg::*;
;
    // Stimulus
    logic           sys_clk_i = 1'b0;
    logic           reset_i = 1'b1;
    np_req_type     np_req;
    pcm_state_type  pcm_state_i = PCM_OFF;
    line_state_type line_state_i = LS_IDLE;
    logic           config_override_i = 1'b0;
    logic [9:0]     rx_byte_i = 10'h155;
    logic [4:0]     tx_symbol_i = 5'h14;
    logic [4:0]     maintenance_line_state_i = 5'h0B;
    logic [9:0]     tx_byte_i = 10'h001;
    logic           tx_parity_i = 1'b0;
    logic           tx_byte_valid_i = 1'b0;
    logic           violation_symbol_i = 1'b0;
    logic           idle_gap_detect_i = 1'b0;
    logic           idle_min_detect_i = 1'b0;
    // Observed outputs
    logic [15:0]     np_data_o;
    logic            np_data_oe_o;
    logic [15:0]     noise_event_timer_o;
    logic [9:0]      rx_byte_o;
    logic [4:0]      transmit_symbol_port_o;
    logic [7:0]      viol_cnt;
    event_pulse_type events_o;
    logic            external_loop_pin_n_o;
    // Bench state
    int          fail_count = 0;
    int          n_tests = 0;
    int          ev_cnt [6];
    int          got;
    logic [15:0] rd_d;
    logic        rd_oe;

    always #20 sys_clk_i = ~sys_clk_i;

    // Connection timer inputs and counter clears are left idle
    phy_control_a_upper_bits DUT (
        .*, .np_req_i(np_req), .noise_limit_value_i(16'h0005), .conn_load_i(1'b0),
        .conn_load_value_i(16'h0000), .connection_timer_o(), .violation_clear_i(1'b0),
        .idle_gap_clear_i(1'b0), .violation_symbol_counter_o(viol_cnt),
        .min_idle_gap_counter_o());

    np_host_model u_np (.sys_clk_i(sys_clk_i), .np_req_o(np_req), .np_data_i(np_data_o),
        .np_data_oe_i(np_data_oe_o));

    // Tally of event pulses, one slot per bit of the event struct
    always @(posedge sys_clk_i)
        for (int i = 0; i < 6; i++)
            if (events_o[i] === 1'b1)
                ev_cnt[i]++;

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Pulse one counter input n times; k 0 violation, 1 idle gap, 2 idle minimum
    task pulses(input int k, input int n, output int cnt);
        int base;
        base = ev_cnt[3-k];
        repeat (n)
        begin
            @(posedge sys_clk_i);
            {violation_symbol_i, idle_gap_detect_i, idle_min_detect_i} <= 3'b100 >> k;
            @(posedge sys_clk_i);
            {violation_symbol_i, idle_gap_detect_i, idle_min_detect_i} <= 3'b000;
        end
        repeat (4) @(posedge sys_clk_i);
        cnt = ev_cnt[3-k] - base;
    endtask

    // One transmit byte with the given parity bit; returns parity errors seen
    task par(input logic p, output int cnt);
        int base;
        base = ev_cnt[0];
        @(posedge sys_clk_i);
        tx_parity_i <= p;
        tx_byte_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        tx_byte_valid_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        cnt = ev_cnt[0] - base;
    endtask

    // Idle then noise; cycles until expiry, capped at 400
    task noise_run(output int cyc);
        int base;
        base = ev_cnt[5];
        repeat (3) @(posedge sys_clk_i);
        line_state_i <= LS_NOISE;
        cyc = 0;
        while (ev_cnt[5] == base && cyc < 400)
        begin
            @(posedge sys_clk_i);
            cyc++;
        end
        line_state_i <= LS_IDLE;
    endtask

    // Hang guard, far beyond the test length
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        finish_test;
    end

    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        u_np.rd(5'h00, rd_d, rd_oe);
        check(rd_d, 16'h0000);
        check(external_loop_pin_n_o, 1'b1);
        $display("test reset done");
        u_np.wr(5'h00, 16'hFFFF);
        u_np.rd(5'h00, rd_d, rd_oe);
        check(rd_d, 16'h7F80);
        check(external_loop_pin_n_o, 1'b0);
        pcm_state_i <= PCM_ACTIVE;
        u_np.wr(5'h00, 16'h0000);
        u_np.rd(5'h00, rd_d, rd_oe);
        check(rd_d, 16'h3000);
        u_np.wr(5'h05, 16'h0800);
        u_np.rd(5'h05, rd_d, rd_oe);
        check(rd_oe, 1'b0);
        $display("test access done");
        u_np.wr(5'h00, 16'h0800);
        u_np.rd(5'h00, rd_d, rd_oe);
        check(rd_d, 16'h3800);
        check(rx_byte_o, 10'h155);
        config_override_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        check(rx_byte_o, 10'h3FF);
        config_override_i <= 1'b0;
        pcm_state_i <= PCM_MAINTENANCE_STATE;
        repeat (3) @(posedge sys_clk_i);
        check(rx_byte_o, 10'h3FF);
        check(transmit_symbol_port_o, 5'h0B);
        $display("test scrub done");
        pcm_state_i <= PCM_OFF;
        u_np.wr(5'h00, 16'h0000);
        pulses(0, 3, got);
        check(got, 3);
        pulses(1, 2, got);
        check(got, 2);
        u_np.wr(5'h00, 16'h0300);
        pulses(0, 252, got);
        check(got, 0);
        pulses(0, 1, got);
        check(got, 1);
        check(viol_cnt, 8'h00);
        pulses(1, 13, got);
        check(got, 0);
        pulses(1, 1, got);
        check(got, 1);
        pulses(2, 2, got);
        check(got, 2);
        $display("test counters done");
        u_np.wr(5'h00, 16'h0400);
        par(1'b0, got);
        check(got, 1);
        par(1'b1, got);
        check(got, 0);
        u_np.wr(5'h00, 16'h0000);
        par(1'b0, got);
        check(got, 0);
        $display("test parity done");
        pcm_state_i <= PCM_MAINTENANCE_STATE;
        u_np.wr(5'h00, 16'h6000);
        noise_run(got);
        check(got >= 8 && got <= 20, 1'b1);
        u_np.wr(5'h00, 16'h4000);
        noise_run(got);
        check(got >= 36 && got <= 64, 1'b1);
        u_np.wr(5'h00, 16'h2080);
        noise_run(got);
        check(got, 400);
        $display("test noise timer done");
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        u_np.rd(5'h00, rd_d, rd_oe);
        check(rd_d, 16'h0000);
        check(external_loop_pin_n_o, 1'b1);
        $display("test second reset done");
        finish_test;
    end
endmodule

bind phy_control_a_upper_bits phy_ctrl_a_checker #(.NOISE_WIDTH(NOISE_WIDTH)) u_chk (.*);

`default_nettype wire
